// ===== rtl/smc_pkg.sv
// Shared constants and carrier types of the standby mode controller.
// Assumes one 100 MHz system clock and an 8-bit register port.
package smc_pkg;

	// --------------------------------
	// Clock rates
	// --------------------------------
	localparam int SMC_CLK_HZ = 100_000_000;
	localparam int SMC_FC_HZ = 16_000_000;
	localparam int SMC_FS_HZ = 32_768;
	localparam int SMC_HF_DIV = SMC_CLK_HZ / SMC_FC_HZ;
	localparam int SMC_LF_DIV = SMC_CLK_HZ / SMC_FS_HZ;
	localparam int SMC_DIV_W = 12;
	localparam int SMC_WU_W = 18;

	// --------------------------------
	// Register map and fields
	// --------------------------------
	localparam logic [7:0] SMC_ADDR_CTRL_ONE = 8'h38;
	localparam logic [7:0] SMC_ADDR_CTRL_TWO = 8'h39;
	localparam logic [7:0] SMC_ADDR_KEY_EN = 8'h3A;
	localparam logic [7:0] SMC_ADDR_STATUS = 8'h3B;
	localparam int SMC_B_HALT = 7;
	localparam int SMC_B_REL = 6;
	localparam int SMC_B_RET = 5;
	localparam int SMC_B_HOLD = 4;
	localparam int SMC_B_WU_HI = 3;
	localparam int SMC_B_WU_LO = 2;
	localparam int SMC_B_XEN = 7;
	localparam int SMC_B_XTEN = 6;
	localparam int SMC_B_SYSCK = 5;
	localparam int SMC_B_NAP = 4;
	localparam int SMC_PC_STEP = 2;

	// --------------------------------
	// Types
	// --------------------------------
	typedef enum logic [2:0] {
		SMC_RUN = 3'h0,
		SMC_HALT = 3'h1,
		SMC_WARM = 3'h3,
		SMC_NAP = 3'h2
	} smc_state_t;

	typedef struct packed {
		logic cpu_stop;
		logic wdt_stop;
		logic periph_stop;
		logic tg_clear;
		logic resume;
		logic irq_service;
		logic core_reset_req;
	} smc_core_t;

	typedef struct packed {
		logic hf_en;
		logic lf_en;
	} smc_osc_t;

	typedef struct packed {
		logic port_hiz;
		logic wake_pin_hiz;
	} smc_port_t;

	typedef struct packed {
		smc_state_t state;
		logic halt_req;
		logic release_type_sel;
		logic return_mode_sel;
		logic halt_port_hold;
		logic [1:0] warmup_sel;
		logic xen;
		logic xten;
		logic sysck;
		logic nap_req;
		logic [3:0] key_wake_en;
		logic pin_prev;
		logic wu_start;
		logic [SMC_DIV_W-1:0] hf_cnt;
		logic [SMC_DIV_W-1:0] lf_cnt;
		logic [15:0] resume_pc;
		logic [7:0] rdata;
		smc_core_t core;
		smc_osc_t osc;
		smc_port_t port;
	} smc_regs_t;

	localparam smc_regs_t SMC_REGS_RST = '{state: SMC_RUN, xen: 1'b1,
		osc: '{hf_en: 1'b1, lf_en: 1'b0}, default: '0};

endpackage : smc_pkg

// ===== rtl/smc_sync.sv
// Two-flop synchroniser for asynchronous pins.
// Assumes d comes from outside the clk_sys domain.
`timescale 1ns/1ns
module smc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} smc_sync_st_t;

	smc_sync_st_t st_ff;
	smc_sync_st_t nxt_st;

	// First stage feeds only the second
	always_comb begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '{s2: RST_VAL, s1: RST_VAL};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule : smc_sync

// ===== rtl/smc_warmup.sv
// Oscillator warm-up counter, advanced by a tick enable.
// Assumes target is at least one when start is pulsed.
`timescale 1ns/1ns
module smc_warmup #(
	parameter int CNT_W = 18
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start,
	input wire logic [CNT_W-1:0] target,
	input wire logic tick_en,
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] lim;
	} smc_wu_st_t;

	smc_wu_st_t st_ff;
	smc_wu_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (start) begin
			nxt_st.busy = 1'b1;
			nxt_st.cnt = '0;
			nxt_st.lim = target;
		end else if (st_ff.busy && tick_en) begin
			// [R27] exact count end
			if (st_ff.cnt == st_ff.lim - CNT_W'(1)) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy = st_ff.busy;
	assign done = st_ff.done;
endmodule : smc_warmup

// ===== rtl/smc_ctrl.sv
// Standby mode controller: deep halt and CPU-nap sequencing.
// Assumes the CPU core obeys the stop, resume and service strobes,
// and that wake, key-wake and reset pins are asynchronous.
`timescale 1ns/1ns

// Function
// [R1] Halt bit write enters deep halt
// [R2] Oscillators off, all operation stopped
// [R3] Memory, registers, port latches retained
// [R4] Prescaler cleared at entry, restart cleared
// [R5] Resume address is instruction plus two
// [R6] Release type bit: one means level
// [R7] Edge release must not use key-wake
// [R8] Level release: pin high or key low
// [R9] Active wake at request skips halt
// [R10] Software checks pins before level halt
// [R11] Restart oscillators per return mode
// [R12] Warm-up interval, four selectable lengths
// [R13] Resume after warm-up ends
// [R14] Reset pin low ends deep halt
// [R15] Software masks and cleans interrupts
// [R16] Nap stops CPU and watchdog only
// [R17] Software nap entry order
// [R18] Nap bit self-clears, mode restored
// [R19] Reset pin ends nap, single fast
// [R20] Master off: resume without service
// [R21] Master on: start service routine
// [R22] Watchdog irq blocks nap entry
// [R23] Warm-up counts fast and slow tables
// [R24] Return mode bit, reset overrides
// [R25] Port hold bit: high-z or driven
// [R26] Wake pins sampled through synchronisers
// [R27] Warm-up counted on selected oscillator
module smc_ctrl #(
	parameter int HF_DIV = smc_pkg::SMC_HF_DIV,
	parameter int LF_DIV = smc_pkg::SMC_LF_DIV,
	parameter int WU_FAST_0 = 3 * (1 << 16),
	parameter int WU_FAST_1 = 1 << 16,
	parameter int WU_FAST_2 = 3 * (1 << 14),
	parameter int WU_FAST_3 = 1 << 14,
	parameter int WU_SLOW_0 = 3 * (1 << 13),
	parameter int WU_SLOW_1 = 1 << 13,
	parameter int WU_SLOW_2 = 3 * (1 << 6),
	parameter int WU_SLOW_3 = 1 << 6
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] insn_addr,
	input wire logic irq_master_enable,
	input wire logic [7:0] irq_source_enable,
	input wire logic [7:0] irq_pending_latch,
	input wire logic watchdog_irq,
	input wire logic port2_bit0,
	input wire logic [3:0] key_wake_inputs,
	input wire logic reset_pin_n,
	output smc_pkg::smc_core_t core_ctl,
	output smc_pkg::smc_osc_t osc_ctl,
	output smc_pkg::smc_port_t port_ctl,
	output logic [15:0] resume_pc,
	output logic [1:0] op_mode
);
	import smc_pkg::*;

	// --------------------------------
	// Parameter checks
	// --------------------------------
	localparam int WU_MAX = 1 << SMC_WU_W;
	localparam int DIV_MAX = 1 << SMC_DIV_W;

	if (HF_DIV < 1 || HF_DIV >= DIV_MAX || LF_DIV < 1 || LF_DIV >= DIV_MAX) begin : g_bad_div
		$error("smc_ctrl: divider out of range");
	end
	if (WU_FAST_0 < 1 || WU_FAST_0 >= WU_MAX || WU_FAST_1 < 1 || WU_FAST_1 >= WU_MAX ||
		WU_FAST_2 < 1 || WU_FAST_2 >= WU_MAX || WU_FAST_3 < 1 || WU_FAST_3 >= WU_MAX ||
		WU_SLOW_0 < 1 || WU_SLOW_0 >= WU_MAX || WU_SLOW_1 < 1 || WU_SLOW_1 >= WU_MAX ||
		WU_SLOW_2 < 1 || WU_SLOW_2 >= WU_MAX || WU_SLOW_3 < 1 || WU_SLOW_3 >= WU_MAX) begin : g_bad_wu
		$error("smc_ctrl: warm-up count out of range");
	end

	localparam logic [SMC_DIV_W-1:0] HF_LAST = SMC_DIV_W'(HF_DIV - 1);
	localparam logic [SMC_DIV_W-1:0] LF_LAST = SMC_DIV_W'(LF_DIV - 1);

	// --------------------------------
	// Pin synchronisers
	// --------------------------------
	logic [5:0] pins_s;
	logic wake_pin_s;
	logic [3:0] keys_s;
	logic rst_pin_n_s;

	// [R26] pins synchronised first
	smc_sync #(
		.W(6),
		.RST_VAL(6'h3E)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.d({reset_pin_n, key_wake_inputs, port2_bit0}),
		.q(pins_s)
	);

	assign wake_pin_s = pins_s[0];
	assign keys_s = pins_s[4:1];
	assign rst_pin_n_s = pins_s[5];

	// --------------------------------
	// State and warm-up counter
	// --------------------------------
	smc_regs_t st_ff;
	smc_regs_t nxt_st;
	logic hf_tick;
	logic lf_tick;
	logic wu_busy;
	logic wu_done;
	logic [SMC_WU_W-1:0] wu_target;
	logic wake_level;
	logic wake_edge;
	logic nap_release;

	// [R23] warm-up table select
	always_comb begin
		case ({st_ff.return_mode_sel, st_ff.warmup_sel})
			3'h0: wu_target = SMC_WU_W'(WU_FAST_0);
			3'h1: wu_target = SMC_WU_W'(WU_FAST_1);
			3'h2: wu_target = SMC_WU_W'(WU_FAST_2);
			3'h3: wu_target = SMC_WU_W'(WU_FAST_3);
			3'h4: wu_target = SMC_WU_W'(WU_SLOW_0);
			3'h5: wu_target = SMC_WU_W'(WU_SLOW_1);
			3'h6: wu_target = SMC_WU_W'(WU_SLOW_2);
			3'h7: wu_target = SMC_WU_W'(WU_SLOW_3);
			default: wu_target = SMC_WU_W'(WU_FAST_0);
		endcase
	end

	// [R27] ticks of the return oscillator
	smc_warmup #(
		.CNT_W(SMC_WU_W)
	) u_warmup (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(st_ff.wu_start),
		.target(wu_target),
		.tick_en(st_ff.return_mode_sel ? lf_tick : hf_tick),
		.busy(wu_busy),
		.done(wu_done)
	);

	// Oscillator ticks only while that oscillator runs
	assign hf_tick = st_ff.osc.hf_en && (st_ff.hf_cnt == HF_LAST);
	assign lf_tick = st_ff.osc.lf_en && (st_ff.lf_cnt == LF_LAST);

	// [R8] level wake: pin high or enabled key low
	assign wake_level = wake_pin_s | (|(st_ff.key_wake_en & ~keys_s));
	// [R7] edge wake watches only the wake pin
	assign wake_edge = wake_pin_s & ~st_ff.pin_prev;
	assign nap_release = |(irq_pending_latch & irq_source_enable);

	// --------------------------------
	// Next-state logic
	// --------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.wu_start = 1'b0;
		nxt_st.pin_prev = wake_pin_s;
		nxt_st.core.tg_clear = 1'b0;
		nxt_st.core.resume = 1'b0;
		nxt_st.core.irq_service = 1'b0;
		nxt_st.core.core_reset_req = 1'b0;
		nxt_st.rdata = 8'h00;
		nxt_st.hf_cnt = (st_ff.hf_cnt == HF_LAST) ? '0 : st_ff.hf_cnt + SMC_DIV_W'(1);
		nxt_st.lf_cnt = (st_ff.lf_cnt == LF_LAST) ? '0 : st_ff.lf_cnt + SMC_DIV_W'(1);

		// Register reads, data valid one cycle later
		if (reg_rd) begin
			case (reg_addr)
				SMC_ADDR_CTRL_ONE: begin
					nxt_st.rdata[SMC_B_HALT] = st_ff.halt_req;
					nxt_st.rdata[SMC_B_REL] = st_ff.release_type_sel;
					nxt_st.rdata[SMC_B_RET] = st_ff.return_mode_sel;
					nxt_st.rdata[SMC_B_HOLD] = st_ff.halt_port_hold;
					nxt_st.rdata[SMC_B_WU_HI:SMC_B_WU_LO] = st_ff.warmup_sel;
				end
				SMC_ADDR_CTRL_TWO: begin
					nxt_st.rdata[SMC_B_XEN] = st_ff.xen;
					nxt_st.rdata[SMC_B_XTEN] = st_ff.xten;
					nxt_st.rdata[SMC_B_SYSCK] = st_ff.sysck;
					nxt_st.rdata[SMC_B_NAP] = st_ff.nap_req;
				end
				SMC_ADDR_KEY_EN: begin
					nxt_st.rdata[3:0] = st_ff.key_wake_en;
				end
				SMC_ADDR_STATUS: begin
					nxt_st.rdata[2:0] = st_ff.state;
				end
				default: begin
					nxt_st.rdata = 8'h00;
				end
			endcase
		end

		case (st_ff.state)
			SMC_RUN: begin
				if (reg_wr) begin
					case (reg_addr)
						SMC_ADDR_CTRL_ONE: begin
							nxt_st.release_type_sel = reg_wdata[SMC_B_REL];
							nxt_st.return_mode_sel = reg_wdata[SMC_B_RET];
							nxt_st.halt_port_hold = reg_wdata[SMC_B_HOLD];
							nxt_st.warmup_sel = reg_wdata[SMC_B_WU_HI:SMC_B_WU_LO];
							// [R1] halt request bit
							if (reg_wdata[SMC_B_HALT]) begin
								nxt_st.halt_req = 1'b1;
								// [R5] resume two ahead
								nxt_st.resume_pc = insn_addr + 16'(SMC_PC_STEP);
								nxt_st.core.cpu_stop = 1'b1;
								nxt_st.core.wdt_stop = 1'b1;
								nxt_st.core.periph_stop = 1'b1;
								// [R9] wake already active
								if (reg_wdata[SMC_B_REL] && wake_level) begin
									nxt_st.state = SMC_WARM;
									nxt_st.wu_start = 1'b1;
								end else begin
									// [R2] oscillators off
									nxt_st.state = SMC_HALT;
									nxt_st.osc = '0;
									// [R4] prescaler cleared
									nxt_st.core.tg_clear = 1'b1;
									// [R25] port drive per hold bit
									nxt_st.port.port_hiz = ~reg_wdata[SMC_B_HOLD];
									nxt_st.port.wake_pin_hiz = 1'b1;
								end
							end
						end
						SMC_ADDR_CTRL_TWO: begin
							nxt_st.xen = reg_wdata[SMC_B_XEN];
							nxt_st.xten = reg_wdata[SMC_B_XTEN];
							nxt_st.sysck = reg_wdata[SMC_B_SYSCK];
							nxt_st.osc.hf_en = reg_wdata[SMC_B_XEN];
							nxt_st.osc.lf_en = reg_wdata[SMC_B_XTEN];
							// [R22] watchdog irq wins over nap
							if (reg_wdata[SMC_B_NAP] && !watchdog_irq) begin
								// [R16] CPU and watchdog stop
								nxt_st.state = SMC_NAP;
								nxt_st.nap_req = 1'b1;
								nxt_st.resume_pc = insn_addr + 16'(SMC_PC_STEP);
								nxt_st.core.cpu_stop = 1'b1;
								nxt_st.core.wdt_stop = 1'b1;
							end
						end
						SMC_ADDR_KEY_EN: begin
							nxt_st.key_wake_en = reg_wdata[3:0];
						end
						default: begin
							nxt_st.key_wake_en = st_ff.key_wake_en;
						end
					endcase
				end
			end
			SMC_HALT: begin
				// [R3] everything frozen; prescaler held clear
				nxt_st.core.tg_clear = 1'b1;
				// [R6] level or edge release
				if (st_ff.release_type_sel ? wake_level : wake_edge) begin
					nxt_st.state = SMC_WARM;
					nxt_st.wu_start = 1'b1;
					nxt_st.core.tg_clear = 1'b0;
					// [R11] restart per return mode
					nxt_st.osc.hf_en = ~st_ff.return_mode_sel;
					nxt_st.osc.lf_en = st_ff.return_mode_sel | st_ff.xten;
				end
			end
			SMC_WARM: begin
				// [R12] halted until warm-up ends
				nxt_st.osc.hf_en = ~st_ff.return_mode_sel;
				nxt_st.osc.lf_en = st_ff.return_mode_sel | st_ff.xten;
				if (wu_done) begin
					// [R13] resume next instruction
					nxt_st.state = SMC_RUN;
					nxt_st.halt_req = 1'b0;
					nxt_st.core.cpu_stop = 1'b0;
					nxt_st.core.wdt_stop = 1'b0;
					nxt_st.core.periph_stop = 1'b0;
					nxt_st.core.resume = 1'b1;
					nxt_st.port = '0;
					// [R24] return mode bit
					nxt_st.sysck = st_ff.return_mode_sel;
					nxt_st.xen = ~st_ff.return_mode_sel;
					nxt_st.xten = st_ff.return_mode_sel | st_ff.xten;
				end
			end
			SMC_NAP: begin
				if (nap_release) begin
					// [R18] nap bit self-clears
					nxt_st.state = SMC_RUN;
					nxt_st.nap_req = 1'b0;
					nxt_st.core.cpu_stop = 1'b0;
					nxt_st.core.wdt_stop = 1'b0;
					// [R21] service when master enabled
					nxt_st.core.irq_service = irq_master_enable;
					// [R20] plain resume otherwise
					nxt_st.core.resume = ~irq_master_enable;
				end
			end
			default: begin
				nxt_st.state = SMC_RUN;
			end
		endcase

		// [R14] reset pin ends any standby
		// [R19] back to single-clock fast mode
		if (!rst_pin_n_s) begin
			nxt_st = SMC_REGS_RST;
			nxt_st.pin_prev = wake_pin_s;
			nxt_st.core.core_reset_req = 1'b1;
		end
	end

	// --------------------------------
	// State register
	// --------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_ff <= SMC_REGS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// --------------------------------
	// Outputs
	// --------------------------------
	assign reg_rdata = st_ff.rdata;
	assign core_ctl = st_ff.core;
	assign osc_ctl = st_ff.osc;
	assign port_ctl = st_ff.port;
	assign resume_pc = st_ff.resume_pc;
	// Mode: 0 single fast, 1 dual fast, 3 slow
	assign op_mode = st_ff.sysck ? 2'h3 : (st_ff.xten ? 2'h1 : 2'h0);

endmodule : smc_ctrl

// ===== verification/smc_far_side.sv
// Far-side model: wake pins, reset pin and the interrupt latches of the core.
// Assumes the bench commands pin levels and interrupt raises at clock edges.
`timescale 1ns/1ns
module smc_far_side (
	input wire logic clk_sys,
	input wire logic reset,
	input wire smc_pkg::smc_core_t core_ctl,
	input wire logic wake_cmd,
	input wire logic [3:0] key_cmd,
	input wire logic rst_cmd,
	input wire logic [7:0] irq_cmd,
	output logic port2_bit0,
	output logic [3:0] key_wake_inputs,
	output logic reset_pin_n,
	output logic [7:0] irq_pending_latch
);
	import smc_pkg::*;
	logic [7:0] pend_ff;
	// ----------------------------
	// Pins
	// ----------------------------
	// Key pins are active low, reset pin is active low
	assign port2_bit0 = wake_cmd;
	assign key_wake_inputs = ~key_cmd;
	assign reset_pin_n = ~rst_cmd;
	// ----------------------------
	// Interrupt latches
	// ----------------------------
	// Software clears latches after release
	always_ff @(posedge clk_sys) begin
		if (reset || core_ctl.resume || core_ctl.irq_service) begin
			pend_ff <= 8'h00;
		end else begin
			pend_ff <= pend_ff | irq_cmd;
		end
	end
	assign irq_pending_latch = pend_ff;
endmodule : smc_far_side

// ===== verification/smc_checker.sv
// Port-level assertions of the standby mode controller.
// Assumes one clock and a two-flop delay on the reset pin.
`timescale 1ns/1ns
module smc_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] insn_addr,
	input wire logic irq_master_enable,
	input wire logic [7:0] irq_source_enable,
	input wire logic [7:0] irq_pending_latch,
	input wire logic watchdog_irq,
	input wire logic reset_pin_n,
	input wire smc_pkg::smc_core_t core_ctl,
	input wire smc_pkg::smc_osc_t osc_ctl,
	input wire smc_pkg::smc_port_t port_ctl,
	input wire logic [15:0] resume_pc,
	input wire logic [1:0] op_mode
);
	import smc_pkg::*;
	logic [1:0] pin_ff;
	logic pin_ok, wr_halt, wr_nap, in_nap;
	// Reset pin must be high long enough to have passed the synchroniser
	always_ff @(posedge clk_sys) pin_ff <= {pin_ff[0], reset_pin_n};
	assign pin_ok = reset_pin_n && (&pin_ff);
	assign wr_halt = reg_wr && reg_addr == SMC_ADDR_CTRL_ONE && reg_wdata[SMC_B_HALT]
		&& !reg_wdata[SMC_B_REL] && !core_ctl.cpu_stop && pin_ok;
	assign wr_nap = reg_wr && reg_addr == SMC_ADDR_CTRL_TWO && reg_wdata[SMC_B_NAP]
		&& !core_ctl.cpu_stop && pin_ok;
	assign in_nap = core_ctl.wdt_stop && !core_ctl.periph_stop && pin_ok;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ----------------------------
	// Assertions
	// ----------------------------
	a_halt_entry: assert property (wr_halt |=> core_ctl.cpu_stop && core_ctl.periph_stop
		&& core_ctl.tg_clear && osc_ctl == '0) else $error("halt entry outputs wrong");
	a_port_hold: assert property (wr_halt |=> port_ctl.wake_pin_hiz
		&& port_ctl.port_hiz == !$past(reg_wdata[SMC_B_HOLD])) else $error("port hold wrong");
	a_pc_step: assert property ($rose(core_ctl.tg_clear) || $rose(in_nap)
		|-> resume_pc == 16'($past(insn_addr) + 16'h0002)) else $error("resume address wrong");
	a_nap_entry: assert property (wr_nap && !watchdog_irq |=> core_ctl.cpu_stop
		&& core_ctl.wdt_stop && !core_ctl.periph_stop) else $error("nap entry wrong");
	a_wdt_block: assert property (wr_nap && watchdog_irq |=> !core_ctl.cpu_stop)
		else $error("nap entered despite watchdog irq");
	a_nap_quiet: assert property (in_nap && |(irq_pending_latch & irq_source_enable)
		&& !irq_master_enable |=> core_ctl.resume && !core_ctl.irq_service && !core_ctl.cpu_stop)
		else $error("nap quiet release wrong");
	a_nap_service: assert property (in_nap && |(irq_pending_latch & irq_source_enable)
		&& irq_master_enable |=> core_ctl.irq_service && !core_ctl.resume && !core_ctl.cpu_stop)
		else $error("nap service release wrong");
	a_reset_pin: assert property (!reset_pin_n [*3] |=> core_ctl.core_reset_req
		&& !core_ctl.cpu_stop && op_mode == 2'h0) else $error("reset pin not obeyed");
	a_resume_pulse: assert property ($fell(core_ctl.periph_stop) && pin_ok
		|-> core_ctl.resume) else $error("halt ended without resume");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	c_halt: cover property (wr_halt);
	c_nap: cover property (in_nap && core_ctl.irq_service);
	c_pin: cover property (core_ctl.core_reset_req);
endmodule : smc_checker

// ===== verification/testbench.sv
// Self-checking bench of the standby mode controller.
// Assumes shortened warm-up counts and dividers set at the instance.
`timescale 1ns/1ns
module testbench;
	import smc_pkg::*;
	logic clk_sys, reset, reg_wr, reg_rd, irq_master_enable, watchdog_irq, wake_cmd, rst_cmd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_source_enable, irq_pending_latch, irq_cmd, d;
	logic [15:0] insn_addr, resume_pc;
	logic [3:0] key_cmd, key_wake_inputs;
	logic port2_bit0, reset_pin_n;
	logic [1:0] op_mode;
	smc_core_t core_ctl;
	smc_osc_t osc_ctl;
	smc_port_t port_ctl;
	int failures, checks, n, s;
	int dur [4];
	// Only three fast counts are shortened; slow selects 2 and 3 keep real, short lengths
	smc_ctrl #(.HF_DIV(1), .LF_DIV(2), .WU_FAST_0(4), .WU_FAST_1(3), .WU_FAST_2(2)) u_smc_ctrl (
		.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .insn_addr,
		.irq_master_enable, .irq_source_enable, .irq_pending_latch, .watchdog_irq, .port2_bit0,
		.key_wake_inputs, .reset_pin_n, .core_ctl, .osc_ctl, .port_ctl, .resume_pc, .op_mode);
	smc_far_side u_smc_far_side (.clk_sys, .reset, .core_ctl, .wake_cmd, .key_cmd, .rst_cmd,
		.irq_cmd, .port2_bit0, .key_wake_inputs, .reset_pin_n, .irq_pending_latch);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------
	// Tasks
	// ----------------------------
	task summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc
	// Each write carries its own instruction address for the resume check
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		insn_addr <= {8'hA0, v};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata, exp);
	endtask : rd
	task wait_pulse(output int k);
		k = 0;
		while (core_ctl.resume !== 1'b1 && core_ctl.irq_service !== 1'b1) begin
			cyc(1);
			k++;
			if (k > 3000) begin
				failures++;
				$display("[FAIL] wait expected pulse seen timeout");
				summarize();
			end
		end
	endtask : wait_pulse
	task wake(input logic v);
		@(posedge clk_sys);
		wake_cmd <= v;
		#1;
	endtask : wake
	// ----------------------------
	// Sequence
	// ----------------------------
	initial begin
		{reg_wr, reg_rd, irq_master_enable, watchdog_irq, wake_cmd, rst_cmd} = '0;
		{reg_addr, reg_wdata, irq_cmd, insn_addr, key_cmd} = '0;
		irq_source_enable = 8'h00;
		failures = 0;
		checks = 0;
		reset = 1'b1;
		cyc(3);
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(SMC_ADDR_CTRL_ONE, 8'h00, "ctrl_one");
		rd(SMC_ADDR_CTRL_TWO, 8'h80, "ctrl_two");
		rd(SMC_ADDR_KEY_EN, 8'h00, "key_en");
		rd(SMC_ADDR_STATUS, 8'h00, "status");
		rd(8'h3C, 8'h00, "unmapped");
		chk("osc", osc_ctl, 16'h2);
		$display("test reset_values done");
		for (s = 0; s < 3; s++) begin
			d = 8'hC0 | 8'(s << 2);
			wr(SMC_ADDR_CTRL_ONE, d);
			chk("cpu_stop", core_ctl.cpu_stop, 1);
			chk("osc off", osc_ctl, 0);
			chk("tg_clear", core_ctl.tg_clear, 1);
			chk("port_hiz", port_ctl.port_hiz, 1);
			chk("resume_pc", resume_pc, {8'hA0, d} + 16'h0002);
			wake(1'b1);
			wait_pulse(dur[s]);
			chk("resume", core_ctl.resume, 1);
			cyc(1);
			chk("osc back", osc_ctl, 16'h2);
			rd(SMC_ADDR_CTRL_ONE, d & 8'h7C, "ctrl_one after");
			// Pin is driven low and held four cycles before the next level-release halt
			wake(1'b0);
			cyc(4);
		end
		for (s = 0; s < 2; s++) chk("warm-up delta", 16'(dur[s] - dur[2]), 16'(2 - s));
		$display("test warmup_lengths done");
		for (s = 0; s < 2; s++) begin
			wr(SMC_ADDR_CTRL_TWO, 8'hC0);
			chk("dual mode", op_mode, 1);
			wr(SMC_ADDR_CTRL_ONE, 8'hC8 | 8'(s << 5));
			wake(1'b1);
			for (n = 0; osc_ctl === 2'b00 && n < 3000; n++) cyc(1);
			chk("osc wait", n < 3000, 1);
			if (n >= 3000) summarize();
			chk("warm osc", osc_ctl, s ? 16'h1 : 16'h3);
			wait_pulse(n);
			chk("return mode", op_mode, s ? 16'h3 : 16'h1);
			rd(SMC_ADDR_CTRL_TWO, s ? 8'h60 : 8'hC0, "ctrl_two after");
			wake(1'b0);
			wr(SMC_ADDR_CTRL_TWO, 8'h80);
			cyc(4);
		end
		$display("test return_modes done");
		wake(1'b1);
		cyc(4);
		wr(SMC_ADDR_CTRL_ONE, 8'hC8);
		chk("skip osc", osc_ctl, 16'h2);
		wait_pulse(n);
		wake(1'b0);
		cyc(4);
		$display("test active_wake done");
		// Edge release ignores a wake pin already high and waits for a new rising edge
		wake(1'b1);
		cyc(4);
		wr(SMC_ADDR_CTRL_ONE, 8'h90);
		chk("port kept", port_ctl.port_hiz, 0);
		chk("wake pin hiz", port_ctl.wake_pin_hiz, 1);
		cyc(8);
		chk("edge hold", core_ctl.cpu_stop, 1);
		wake(1'b0);
		cyc(4);
		wake(1'b1);
		wait_pulse(n);
		chk("edge resume", core_ctl.resume, 1);
		wake(1'b0);
		cyc(4);
		$display("test edge_release done");
		wr(SMC_ADDR_KEY_EN, 8'h04);
		rd(SMC_ADDR_KEY_EN, 8'h04, "key_en");
		wr(SMC_ADDR_CTRL_ONE, 8'hC0);
		key_cmd <= 4'h1;
		cyc(8);
		chk("key masked", core_ctl.cpu_stop, 1);
		wr(SMC_ADDR_CTRL_TWO, 8'h00);
		key_cmd <= 4'h4;
		wait_pulse(n);
		chk("key resume", core_ctl.resume, 1);
		rd(SMC_ADDR_CTRL_TWO, 8'h80, "halt write ignored");
		key_cmd <= 4'h0;
		cyc(4);
		$display("test key_release done");
		for (s = 0; s < 2; s++) begin
			if (s == 0) wr(SMC_ADDR_CTRL_ONE, 8'hC0);
			else wr(SMC_ADDR_CTRL_TWO, 8'hD0);
			@(posedge clk_sys);
			rst_cmd <= 1'b1;
			cyc(4);
			chk("reset req", core_ctl.core_reset_req, 1);
			chk("reset mode", op_mode, 0);
			chk("reset osc", osc_ctl, 16'h2);
			@(posedge clk_sys);
			rst_cmd <= 1'b0;
			cyc(4);
			rd(SMC_ADDR_CTRL_TWO, 8'h80, "ctrl_two reset");
		end
		$display("test reset_pin done");
		for (s = 0; s < 2; s++) begin
			@(posedge clk_sys);
			irq_master_enable <= s[0];
			irq_source_enable <= 8'h08;
			// Master enable and source enable settled before the nap request
			wr(SMC_ADDR_CTRL_TWO, 8'h90);
			chk("nap cpu", core_ctl.cpu_stop & core_ctl.wdt_stop, 1);
			chk("nap periph", core_ctl.periph_stop, 0);
			@(posedge clk_sys);
			irq_cmd <= 8'h04;
			@(posedge clk_sys);
			irq_cmd <= 8'h00;
			cyc(3);
			chk("nap masked", core_ctl.cpu_stop, 1);
			@(posedge clk_sys);
			irq_cmd <= 8'h08;
			@(posedge clk_sys);
			irq_cmd <= 8'h00;
			#1;
			wait_pulse(n);
			chk("service", core_ctl.irq_service, s[0]);
			chk("resume", core_ctl.resume, !s[0]);
			rd(SMC_ADDR_CTRL_TWO, 8'h80, "nap self clear");
		end
		@(posedge clk_sys);
		irq_master_enable <= 1'b0;
		watchdog_irq <= 1'b1;
		wr(SMC_ADDR_CTRL_TWO, 8'h90);
		chk("wdt block", core_ctl.cpu_stop, 0);
		rd(SMC_ADDR_CTRL_TWO, 8'h80, "wdt nap bit");
		@(posedge clk_sys);
		watchdog_irq <= 1'b0;
		$display("test nap_modes done");
		summarize();
	end
endmodule : testbench
bind smc_ctrl smc_checker u_smc_checker (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .insn_addr, .irq_master_enable, .irq_source_enable, .irq_pending_latch,
	.watchdog_irq, .reset_pin_n, .core_ctl, .osc_ctl, .port_ctl, .resume_pc, .op_mode);
